/* adc_scan_seq.sv */
// adc_scan_seq: ahb-lite slave that sequences a 16-input converter into twelve result slots.
// assumes a converter macro that takes conv_start/conv_channel and answers with a
// conv_done level that rises once the result on conv_data is stable.
//
// Operation
// - fixed mode converts the selected input, result into slot select modulo eight.
// - 4-channel scan runs from the group-of-four base up to the select.
// - 4-channel scan stores each input into slot input modulo eight.
// - 8-channel scan runs from input 0 or 8 to select, slots modulo eight.
// - 12-channel scan runs 0 to select into equal slots; selects 12-15 refused.
// - a dma request goes out when a done or monitor event is raised and its dma enable bit is set.
// - dma requests only go out when their enable bit is set.
module adc_scan_seq
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // converter macro
  output logic                   conv_start,
  output logic [CH_W-1:0]        conv_channel,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_data,
  // dma and interrupt
  output logic                   dma_req,
  output logic                   irq
);

  // whole module state
  typedef struct packed {
    seq_state_t                    st;
    logic                          rdy;
    logic [31:0]                   rdata;
    logic                          resp;
    logic                          dp_act;
    logic                          dp_wr;
    logic [ADDR_W-1:0]             dp_addr;
    logic [CH_W-1:0]               sel;
    logic                          scan_en;
    scan_width_t                   width;
    logic                          rpt;
    logic [EV_W-1:0]               dma_en;
    logic [EV_W-1:0]               status;
    logic [EV_W-1:0]               mask;
    logic [RES_W-1:0]              thr;
    logic                          mon_en;
    logic                          mon_abv;
    logic [CH_W-1:0]               cur;
    logic [CH_W-1:0]               first;
    logic [CH_W-1:0]               last;
    logic                          twelve;
    logic [NUM_RES-1:0][RES_W-1:0] res;
    logic                          start;
    logic [CH_W-1:0]               chan;
    logic [2:0]                    sync;
    logic                          done_lvl;
    logic                          irq;
    logic                          dreq;
  } state_t;

  state_t                          s_r;
  state_t                          s_nxt;
  scan_plan_if                     plan ();

  // planner sees the live mode fields; range is latched at start
  assign plan.sel     = s_r.sel;
  assign plan.scan_en = s_r.scan_en;
  assign plan.width   = s_r.width;

  scan_planner u_plan (
    .pl (plan.planner)
  );

  // register read decode, used for every read data phase
  function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    logic [31:0]       w;
    off = a - OFS_RES0;
    w   = '0;
    unique case (a)
      OFS_MODE: begin
        w[MODE_SEL_LSB +: CH_W] = s.sel;
        w[MODE_SCAN_BIT]        = s.scan_en;
        w[MODE_WID_LSB +: 2]    = s.width;
        w[MODE_RPT_BIT]         = s.rpt;
      end
      OFS_CTRL: begin
        w[CTRL_BUSY_BIT]        = (s.st != ST_IDLE);
        w[CTRL_CUR_LSB +: CH_W] = s.cur;
      end
      OFS_DMA: begin
        w[EV_W-1:0] = s.dma_en;
      end
      OFS_STAT: begin
        w[EV_W-1:0] = s.status;
      end
      OFS_MASK: begin
        w[EV_W-1:0] = s.mask;
      end
      OFS_MON: begin
        w[MON_THR_LSB +: RES_W] = s.thr;
        w[MON_EN_BIT]           = s.mon_en;
        w[MON_ABV_BIT]          = s.mon_abv;
      end
      default: begin
        // result slots, unmapped words read as zero
        if (a >= OFS_RES0 && a < OFS_RES_END && a[1:0] == 2'b00) begin
          w[RES_W-1:0] = s.res[off[ADDR_W-1:2]];
        end
      end
    endcase
    return w;
  endfunction

  // next-state logic
  always_comb begin
    logic              acc;
    logic              wr_now;
    logic              rd_fill;
    logic              go;
    logic              done_edge;
    logic              mon_hit;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   w1c;
    logic [CH_W-1:0]   slot;
    acc       = 1'b0;
    wr_now    = 1'b0;
    rd_fill   = 1'b0;
    go        = 1'b0;
    done_edge = 1'b0;
    mon_hit   = 1'b0;
    ev        = EV_NONE;
    w1c       = EV_NONE;
    slot      = '0;
    s_nxt     = s_r;

    // converter done passes three flops; a level counts once the last two agree
    s_nxt.sync = {s_r.sync[1:0], conv_done};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.done_lvl = s_r.sync[2];
      done_edge      = s_r.sync[2] && !s_r.done_lvl;
    end

    // bus data phase: reads take one wait state so hrdata leaves a flop
    wr_now  = s_r.dp_act && s_r.dp_wr && s_r.rdy;
    rd_fill = s_r.dp_act && !s_r.dp_wr && !s_r.rdy;
    if (rd_fill) begin
      s_nxt.rdata = read_word(s_r, s_r.dp_addr);
      s_nxt.rdy   = 1'b1;
    end
    if (s_r.dp_act && s_r.rdy) begin
      s_nxt.dp_act = 1'b0;
    end

    // address phase accepted only while this slave is ready
    acc = hsel && hready && htrans[HTRANS_ACT] && s_r.rdy;
    if (acc) begin
      s_nxt.dp_act  = 1'b1;
      s_nxt.dp_wr   = hwrite;
      s_nxt.dp_addr = haddr[ADDR_W-1:0];
      s_nxt.rdy     = hwrite;
    end

    // register writes; a start while busy or on an illegal plan is dropped
    if (wr_now) begin
      unique case (s_r.dp_addr)
        OFS_MODE: begin
          s_nxt.sel     = hwdata[MODE_SEL_LSB +: CH_W];
          s_nxt.scan_en = hwdata[MODE_SCAN_BIT];
          s_nxt.width   = scan_width_t'(hwdata[MODE_WID_LSB +: 2]);
          s_nxt.rpt     = hwdata[MODE_RPT_BIT];
        end
        OFS_CTRL: begin
          go = hwdata[CTRL_GO_BIT] && (s_r.st == ST_IDLE) && plan.legal;
        end
        OFS_DMA: begin
          s_nxt.dma_en = hwdata[EV_W-1:0];
        end
        OFS_STAT: begin
          w1c = hwdata[EV_W-1:0];
        end
        OFS_MASK: begin
          s_nxt.mask = hwdata[EV_W-1:0];
        end
        OFS_MON: begin
          s_nxt.thr     = hwdata[MON_THR_LSB +: RES_W];
          s_nxt.mon_en  = hwdata[MON_EN_BIT];
          s_nxt.mon_abv = hwdata[MON_ABV_BIT];
        end
        default: begin
          // unmapped or read-only words ignore writes
        end
      endcase
    end

    // conversion sequencer
    s_nxt.start = 1'b0;
    unique case (s_r.st)
      ST_IDLE: begin
        if (go) begin
          s_nxt.first  = plan.first;
          s_nxt.last   = plan.last;
          s_nxt.twelve = plan.twelve;
          s_nxt.cur    = plan.first;
          s_nxt.st     = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // one input at a time: the next start waits for the previous result
        s_nxt.start = 1'b1;
        s_nxt.chan  = s_r.cur;
        s_nxt.st    = ST_WAIT;
      end
      ST_WAIT: begin
        if (done_edge) begin
          slot = result_slot(s_r.cur, s_r.twelve);
          s_nxt.res[slot] = conv_data;
          mon_hit = s_r.mon_en && (s_r.mon_abv ? (conv_data > s_r.thr)
                                               : (conv_data <= s_r.thr));
          ev[EV_MON] = mon_hit;
          if (s_r.cur == s_r.last) begin
            ev[EV_DONE] = 1'b1;
            // repeat is sampled live so clearing it ends the run after this scan
            s_nxt.cur = s_r.first;
            s_nxt.st  = s_r.rpt ? ST_ISSUE : ST_IDLE;
          end else begin
            s_nxt.cur = s_r.cur + 1'b1;
            s_nxt.st  = ST_ISSUE;
          end
        end
      end
    endcase

    // sticky status: a new event wins over a write-one clear in the same cycle
    s_nxt.status = (s_r.status & ~w1c) | ev;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);

    // dma request pulses once in any cycle that raises an event with its enable set
    s_nxt.dreq = |(ev & s_r.dma_en);
    s_nxt.resp = 1'b0;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.rdy      <= 1'b1;
      s_r.sel      <= SEL_RST;
      s_r.width    <= WID_4;
      s_r.thr      <= THR_RST;
      s_r.status   <= EV_NONE;
      s_r.mask     <= EV_NONE;
      s_r.dma_en   <= EV_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign hreadyout    = s_r.rdy;
  assign hrdata       = s_r.rdata;
  assign hresp        = s_r.resp;
  assign conv_start   = s_r.start;
  assign conv_channel = s_r.chan;
  assign dma_req      = s_r.dreq;
  assign irq          = s_r.irq;

endmodule // adc_scan_seq

/* adc_seq_pkg.sv */
// adc_seq_pkg: register map, field layout and state codes of the adc scan sequencer.
// assumes a single 40 MHz clock domain and a 32-bit ahb-lite register bus.
package adc_seq_pkg;

  // bus and data widths
  localparam int unsigned        ADDR_W        = 8;
  localparam int unsigned        CH_W          = 4;
  localparam int unsigned        RES_W         = 10;
  localparam int unsigned        NUM_RES       = 12;
  localparam int unsigned        EV_W          = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0]  OFS_MODE      = 8'h00;
  localparam logic [ADDR_W-1:0]  OFS_CTRL      = 8'h04;
  localparam logic [ADDR_W-1:0]  OFS_DMA       = 8'h08;
  localparam logic [ADDR_W-1:0]  OFS_STAT      = 8'h0c;
  localparam logic [ADDR_W-1:0]  OFS_MASK      = 8'h10;
  localparam logic [ADDR_W-1:0]  OFS_MON       = 8'h14;
  localparam logic [ADDR_W-1:0]  OFS_RES0      = 8'h40;
  localparam logic [ADDR_W-1:0]  OFS_RES_END   = 8'h70;

  // field positions
  localparam int unsigned        MODE_SEL_LSB  = 0;
  localparam int unsigned        MODE_SCAN_BIT = 4;
  localparam int unsigned        MODE_WID_LSB  = 5;
  localparam int unsigned        MODE_RPT_BIT  = 7;
  localparam int unsigned        CTRL_GO_BIT   = 0;
  localparam int unsigned        CTRL_BUSY_BIT = 8;
  localparam int unsigned        CTRL_CUR_LSB  = 12;
  localparam int unsigned        EV_DONE       = 0;
  localparam int unsigned        EV_MON        = 1;
  localparam int unsigned        MON_THR_LSB   = 0;
  localparam int unsigned        MON_EN_BIT    = 16;
  localparam int unsigned        MON_ABV_BIT   = 17;
  localparam int unsigned        HTRANS_ACT    = 1;

  // reset values
  localparam logic [CH_W-1:0]    SEL_RST       = 4'h0;
  localparam logic [RES_W-1:0]   THR_RST       = 10'h000;
  localparam logic [EV_W-1:0]    EV_NONE       = 2'h0;

  // scan width codes
  typedef enum logic [1:0] {
    WID_4  = 2'h0,
    WID_8  = 2'h1,
    WID_12 = 2'h2
  } scan_width_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b100
  } seq_state_t;

  // result slot of an input: modulo eight, except in 12-channel scan
  function automatic logic [CH_W-1:0] result_slot(input logic [CH_W-1:0] ch,
                                                 input logic              twelve);
    result_slot = twelve ? ch : {1'b0, ch[CH_W-2:0]};
  endfunction

endpackage : adc_seq_pkg

/* scan_plan_if.sv */
// scan_plan_if: carries the channel choice to the planner and the planned range back.
// assumes both ends sit on the same clock; the planner is purely combinational.
interface scan_plan_if;
  import adc_seq_pkg::*;

  logic [CH_W-1:0] sel;
  logic            scan_en;
  scan_width_t     width;
  logic [CH_W-1:0] first;
  logic [CH_W-1:0] last;
  logic            twelve;
  logic            legal;

  modport planner (input sel, input scan_en, input width,
                   output first, output last, output twelve, output legal);
  modport user    (output sel, output scan_en, output width,
                   input first, input last, input twelve, input legal);
endinterface : scan_plan_if

/* scan_planner.sv */
// scan_planner: turns channel select, scan choice and width into a first/last input range.
// assumes the caller latches the range when a conversion run starts.
module scan_planner
  import adc_seq_pkg::*;
(
  // plan request and answer
  scan_plan_if.planner pl
);

  // range per mode; last input is always the selected one
  always_comb begin
    pl.first  = pl.sel;
    pl.last   = pl.sel;
    pl.twelve = 1'b0;
    pl.legal  = 1'b1;
    if (pl.scan_en) begin
      unique case (pl.width)
        WID_4: begin
          pl.first = {pl.sel[CH_W-1:2], 2'b00};
        end
        WID_8: begin
          pl.first = {pl.sel[CH_W-1], 3'b000};
        end
        WID_12: begin
          pl.first  = '0;
          pl.twelve = 1'b1;
          pl.legal  = (pl.sel < CH_W'(NUM_RES));
        end
        default: begin
          pl.legal = 1'b0;                                 // reserved width code
        end
      endcase
    end
  end

endmodule // scan_planner

/* conv_macro_model.sv */
// converter macro model: answers each conv_start with a result after a short or long delay.
// assumes conv_start is a one-cycle pulse on hclk.
module conv_macro_model
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // request
  input  wire logic            conv_start,
  input  wire logic [CH_W-1:0] conv_channel,
  input  wire logic            slow,
  // answer
  output logic                 conv_done,
  output logic [RES_W-1:0]     conv_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy_r;
  logic [3:0] cnt_r;
  // result is the channel over a fixed tag, so every slot is told apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r    <= 1'b0;
      cnt_r     <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else if (conv_start) begin
      busy_r    <= 1'b1;
      cnt_r     <= slow ? 4'hc : 4'h1;
      conv_done <= 1'b0;       // a fresh rise for each conversion
      conv_data <= ~conv_data; // old result no longer held
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r    <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= {conv_channel, 6'h2a};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule // conv_macro_model

/* adc_scan_seq_assertions.sv */
// checker of bus and converter timing at the adc sequencer ports.
// assumes hready is the slave's own hreadyout.
module adc_scan_seq_sva
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic            hclk,
  input wire logic            hresetn,
  // bus
  input wire logic            hsel,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic [31:0]     hrdata,
  input wire logic            hresp,
  // converter and dma
  input wire logic            conv_start,
  input wire logic [CH_W-1:0] conv_channel,
  input wire logic            dma_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // steps of a bus transfer
  sequence take_s;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  sequence wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_read_wait: assert property (take_s ##0 !hwrite |=> wait_s) else $error("read wait wrong");
  a_write_nowait: assert property (take_s ##0 hwrite |=> hreadyout) else $error("write stalled");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("long start");
  a_start_spacing: assert property (conv_start |=> !conv_start [*4]) else $error("starts too close");
  a_chan_stable: assert property (!conv_start |-> $stable(conv_channel)) else $error("channel moved");
  a_dma_single: assert property (dma_req |=> !dma_req) else $error("long dma request");
endmodule // adc_scan_seq_sva

bind adc_scan_seq adc_scan_seq_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
                                          .hrdata, .hresp, .conv_start, .conv_channel, .dma_req);

/* adc_channel_result_mapper_tb_top.sv */
// testbench of the adc sequencer: scan ranges, result slots, dma, irq, refusal, reset.
// assumes the converter model answers every start; hready is the slave's hreadyout.
module adc_channel_result_mapper_tb_top
  import adc_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] mode; logic [3:0] first; logic [3:0] last; logic twelve;} row_t;
  logic             hclk, hresetn, hwrite, slow, hreadyout, hresp, conv_start, conv_done, dma_req, irq;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata, rd_v;
  logic [CH_W-1:0]  conv_channel, ch, slot;
  logic [RES_W-1:0] conv_data;
  logic [CH_W-1:0]  seen[$];
  int               bad_count, comparisons, cyc, dmac;
  logic [7:0]       regs[7] = '{OFS_MODE, OFS_CTRL, OFS_DMA, OFS_STAT, OFS_MASK, OFS_MON, 8'h20};
  // fixed 8, scan4 5 and 13, scan8 12 and 3, scan12 11
  row_t rows[6] = '{'{8'h08, 4'h8, 4'h8, 1'b0}, '{8'h15, 4'h4, 4'h5, 1'b0}, '{8'h1d, 4'hc, 4'hd, 1'b0},
                    '{8'h3c, 4'h8, 4'hc, 1'b0}, '{8'h33, 4'h0, 4'h3, 1'b0}, '{8'h5b, 4'h0, 4'hb, 1'b1}};

  adc_scan_seq DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
                    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .conv_start, .conv_channel,
                    .conv_done, .conv_data, .dma_req, .irq);
  conv_macro_model u_conv (.hclk, .hresetn, .conv_start, .conv_channel, .slow, .conv_done, .conv_data);

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // hang guard, then start and dma monitors
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  always @(posedge hclk) if (conv_start === 1'b1) seen.push_back(conv_channel);
  always @(posedge hclk) if (dma_req === 1'b1) dmac++;

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; entered just after an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_v = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // irq is the completion sign; the guard cuts a hang
  task automatic go(input logic [31:0] mode);
    dmac = 0;
    seen.delete();
    bus(1'b1, OFS_MODE, mode);
    bus(1'b1, OFS_CTRL, 32'h1);
    while (irq !== 1'b1) @(posedge hclk);
  endtask

  initial begin
    {hresetn, htrans, haddr, hwrite, hwdata, slow} = '0;
    @(posedge hclk);
    rst();
    foreach (regs[k]) rdc(regs[k], 32'h0);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rdc(8'h20, 32'h0);
    bus(1'b1, OFS_DMA, 32'h1);
    bus(1'b1, OFS_MASK, 32'h1);
    // table rows, alternating prompt and slow converter
    foreach (rows[i]) begin
      slow <= i[0];
      go({24'h0, rows[i].mode});
      rdc(OFS_STAT, 32'h1);
      chk(dmac, 1);
      chk(seen.size(), rows[i].last - rows[i].first + 1);
      foreach (seen[k]) begin
        ch = rows[i].first + 4'(k);
        slot = rows[i].twelve ? ch : (ch & 4'h7);
        chk({28'h0, seen[k]}, {28'h0, ch});
        rdc(OFS_RES0 + {2'h0, slot, 2'h0}, {22'h0, ch, 6'h2a});
      end
      bus(1'b1, OFS_STAT, 32'h1);
      rdc(OFS_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // 12-channel scan with select 12 and the reserved width code have no range: nothing starts
    seen.delete();
    bus(1'b1, OFS_MODE, 32'h5c);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_MODE, 32'h70);
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (20) @(posedge hclk);
    chk(seen.size(), 0);
    rdc(OFS_STAT, 32'h0);
    // monitor hit raises a request; done request stays off with its enable low
    bus(1'b1, OFS_DMA, 32'h2);
    bus(1'b1, OFS_MASK, 32'h2);
    bus(1'b1, OFS_MON, 32'h3_02ff);
    go(32'h0c);
    repeat (4) @(posedge hclk);
    rdc(OFS_STAT, 32'h3);
    chk(dmac, 1);
    bus(1'b1, OFS_MASK, 32'h0);
    rdc(OFS_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    // repeated fixed conversion keeps going until the repeat bit is cleared
    seen.delete();
    bus(1'b1, OFS_MODE, 32'h88);
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (100) @(posedge hclk);
    bus(1'b1, OFS_MODE, 32'h08);
    repeat (60) @(posedge hclk);
    chk({31'h0, seen.size() > 2}, 32'h1);
    rdc(OFS_CTRL, 32'h8000);
    rdc(OFS_RES0, {22'h0, 4'h8, 6'h2a});
    // reset in mid-scan stops everything and clears the mode
    bus(1'b1, OFS_MODE, 32'h5b);
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (12) @(posedge hclk);
    rst();
    seen.delete();
    repeat (30) @(posedge hclk);
    chk(seen.size(), 0);
    rdc(OFS_MODE, 32'h0);
    close_out();
  end
endmodule // adc_channel_result_mapper_tb_top
